// ==== hdl/limit_status_pkg.sv ====
// constants shared by the limit status register bank and its comparator
package limit_status_pkg;

    // data and channel index widths
    localparam int DATA_W = 8;
    localparam int CHAN_W = 5;
    localparam int GROUP_COUNT = 8;
    localparam int RAIL_COUNT = 6;
    localparam int DIODE_COUNT = 2;

    // register byte addresses on the management read port
    localparam logic [7:0] ADDR_TEMP_SUPPLY = 8'h20;
    localparam logic [7:0] ADDR_ANALOG = 8'h21;
    localparam logic [7:0] ADDR_FAN_TACH = 8'h22;

    // power-on value of every status register and answer to a miss
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // measurement channel numbering on the result stream
    localparam logic [4:0] CH_DIODE_ONE = 5'h00;
    localparam logic [4:0] CH_DIODE_TWO = 5'h01;
    localparam logic [4:0] CH_AUX_NINE = 5'h02;
    localparam logic [4:0] CH_RAIL_BASE = 5'h03;
    localparam logic [4:0] CH_ANALOG_BASE = 5'h09;
    localparam logic [4:0] CH_TACH_BASE = 5'h11;

    // bit positions inside the temperature and supply register
    localparam int BIT_DIODE_ONE = 0;
    localparam int BIT_DIODE_TWO = 1;
    localparam int BIT_RAIL_BASE = 2;

    // thermal alarm release hysteresis, one code step per degree
    localparam int HYST_DEG_C = 5;
    localparam logic signed [8:0] HYST_CODE = 9'(HYST_DEG_C);

    typedef logic [7:0] status_byte_t;

endpackage : limit_status_pkg

// ==== hdl/compare_if.sv ====
// carrier between the status bank and its window comparator
`timescale 1ns/1ns
`default_nettype none
interface compare_if;
    logic [7:0] value;    // converted result under test
    logic [7:0] high;     // high limit
    logic [7:0] low;      // low limit
    logic low_check;      // low limit is checked
    logic is_signed;      // two's complement temperature code
    logic above;          // value above high limit
    logic below;          // value below low limit

    modport requester (
        output value, high, low, low_check, is_signed,
        input above, below
    );
    modport judge (
        input value, high, low, low_check, is_signed,
        output above, below
    );
endinterface : compare_if
`default_nettype wire

// ==== hdl/window_compare.sv ====
// window comparator for one converted result against its limits
`timescale 1ns/1ns
`default_nettype none
module window_compare
    import limit_status_pkg::*;
(
    // compare request and answer
    compare_if.judge port
);

    // signed view used for temperature codes only
    logic signed [8:0] val_ext;
    logic signed [8:0] high_ext;
    logic signed [8:0] low_ext;

    // sign or zero extend so one comparison serves both code types
    always_comb
    begin
        val_ext = {port.is_signed & port.value[DATA_W-1], port.value};
        high_ext = {port.is_signed & port.high[DATA_W-1], port.high};
        low_ext = {port.is_signed & port.low[DATA_W-1], port.low};
        port.above = val_ext > high_ext;
        // tach channels only have a high limit, so low is gated
        port.below = port.low_check & (val_ext < low_ext);
    end

endmodule : window_compare
`default_nettype wire

// ==== hdl/limit_status_registers.sv ====
// read-only limit status registers of the hardware monitor
`timescale 1ns/1ns
`default_nettype none
module limit_status_registers
    import limit_status_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // conversion result stream, one channel per strobe
    input wire logic meas_valid_i,
    input wire logic [4:0] meas_chan_i,
    input wire logic [7:0] meas_value_i,
    input wire logic [7:0] meas_high_i,
    input wire logic [7:0] meas_low_i,
    input wire logic cycle_done_i,
    // thermal alarm limits and diode two mode
    input wire logic [7:0] thermal_alarm_mode_lim_one_i,
    input wire logic [7:0] thermal_alarm_mode_lim_two_i,
    input wire logic diode_two_volt_mode_i,
    // interrupt masks, one bit per status bit
    input wire logic [7:0] mask_temp_supply_i,
    input wire logic [7:0] mask_analog_i,
    input wire logic [7:0] mask_fan_i,
    // register read port behind the serial interface
    input wire logic rd_en_i,
    input wire logic [7:0] rd_addr_i,
    output logic [7:0] rd_data_o,
    output logic rd_valid_o,
    // alarm and alert state
    output logic [1:0] thermal_alarm_mode_active_o,
    output logic alert_o
);

    // comparator link
    compare_if cmp ();

    // per-measurement out-of-window hits for each register
    status_byte_t hit_ts;
    status_byte_t hit_an;
    status_byte_t hit_fan;
    logic oow;             // current measurement out of window
    logic is_tach;         // current channel is a tach channel
    logic is_temp;         // current channel is a diode temperature

    // alarm mode state and its edge events
    logic [1:0] thermal_alarm_mode_reg;
    logic [1:0] thermal_alarm_mode_next;
    logic [1:0] thermal_alarm_mode_ev;   // one-cycle engage or release event

    // flags gathered during the running conversion cycle
    status_byte_t pend_ts_reg;
    status_byte_t pend_ts_next;
    status_byte_t pend_an_reg;
    status_byte_t pend_an_next;
    status_byte_t pend_fan_reg;
    status_byte_t pend_fan_next;

    // visible status registers
    status_byte_t stat_ts_reg;
    status_byte_t stat_ts_next;
    status_byte_t stat_an_reg;
    status_byte_t stat_an_next;
    status_byte_t stat_fan_reg;
    status_byte_t stat_fan_next;

    // read port and alert outputs
    logic [7:0] rd_data_reg;
    logic [7:0] rd_data_next;
    logic rd_valid_reg;
    logic rd_valid_next;
    logic alert_reg;
    logic alert_next;

    // channel classes for the comparator setup
    always_comb
    begin
        is_tach = meas_chan_i >= CH_TACH_BASE;
        is_temp = (meas_chan_i == CH_DIODE_ONE)
            | ((meas_chan_i == CH_DIODE_TWO) & ~diode_two_volt_mode_i);
    end

    // feed the comparator; tach checks skip the low limit
    assign cmp.value = meas_value_i;
    assign cmp.high = meas_high_i;
    assign cmp.low = meas_low_i;
    assign cmp.low_check = ~is_tach;
    assign cmp.is_signed = is_temp;
    assign oow = cmp.above | cmp.below;

    window_compare u_compare (
        .port(cmp.judge)
    );

    // diode bits; in voltage mode bit1 follows aux nine instead
    always_comb
    begin
        hit_ts[BIT_DIODE_ONE] = meas_valid_i & oow
            & (meas_chan_i == CH_DIODE_ONE);
        hit_ts[BIT_DIODE_TWO] = meas_valid_i & oow
            & (diode_two_volt_mode_i ? (meas_chan_i == CH_AUX_NINE)
                                     : (meas_chan_i == CH_DIODE_TWO));
    end

    // one comparator hit decode per status bit
    genvar g;
    generate
        for (g = 0; g < RAIL_COUNT; g++)
        begin : g_rail
            localparam logic [4:0] RAIL_CH = 5'(int'(CH_RAIL_BASE) + g);
            assign hit_ts[BIT_RAIL_BASE + g] = meas_valid_i & oow
                & (meas_chan_i == RAIL_CH);
        end
        for (g = 0; g < GROUP_COUNT; g++)
        begin : g_group
            localparam logic [4:0] AN_CH = 5'(int'(CH_ANALOG_BASE) + g);
            localparam logic [4:0] FAN_CH = 5'(int'(CH_TACH_BASE) + g);
            assign hit_an[g] = meas_valid_i & oow
                & (meas_chan_i == AN_CH);
            assign hit_fan[g] = meas_valid_i & cmp.above
                & (meas_chan_i == FAN_CH);
        end
    endgenerate

    // alarm mode: engage above the limit, release more than 5 degrees below it
    always_comb
    begin
        logic signed [8:0] temp_ext;
        logic signed [8:0] lim_ext;
        logic match;
        temp_ext = 9'sh000;
        lim_ext = 9'sh000;
        match = 1'b0;
        thermal_alarm_mode_next = thermal_alarm_mode_reg;
        thermal_alarm_mode_ev = 2'h0;
        for (int k = 0; k < DIODE_COUNT; k++)
        begin
            temp_ext = {meas_value_i[DATA_W-1], meas_value_i};
            if (k == 0)
            begin
                lim_ext = {thermal_alarm_mode_lim_one_i[DATA_W-1], thermal_alarm_mode_lim_one_i};
                match = meas_chan_i == CH_DIODE_ONE;
            end
            else
            begin
                lim_ext = {thermal_alarm_mode_lim_two_i[DATA_W-1], thermal_alarm_mode_lim_two_i};
                match = (meas_chan_i == CH_DIODE_TWO)
                    & ~diode_two_volt_mode_i;
            end
            if (meas_valid_i & match)
            begin
                if (!thermal_alarm_mode_reg[k] && temp_ext > lim_ext)
                begin
                    // engage: flag the bit once
                    thermal_alarm_mode_next[k] = 1'b1;
                    thermal_alarm_mode_ev[k] = 1'b1;
                end
                else if (thermal_alarm_mode_reg[k] && (temp_ext + HYST_CODE) < lim_ext)
                begin
                    // release: flag the bit once more
                    thermal_alarm_mode_next[k] = 1'b0;
                    thermal_alarm_mode_ev[k] = 1'b1;
                end
            end
        end
        // a diode used as a voltage input has no alarm; drop silently
        if (diode_two_volt_mode_i)
        begin
            thermal_alarm_mode_next[1] = 1'b0;
        end
    end

    // gather hits; a hit in the closing cycle lands in the status
    always_comb
    begin
        status_byte_t ev_ts;
        ev_ts = hit_ts;
        ev_ts[BIT_DIODE_ONE] = hit_ts[BIT_DIODE_ONE] | thermal_alarm_mode_ev[0];
        ev_ts[BIT_DIODE_TWO] = hit_ts[BIT_DIODE_TWO] | thermal_alarm_mode_ev[1];
        stat_ts_next = stat_ts_reg;
        stat_an_next = stat_an_reg;
        stat_fan_next = stat_fan_reg;
        pend_ts_next = pend_ts_reg | ev_ts;
        pend_an_next = pend_an_reg | hit_an;
        pend_fan_next = pend_fan_reg | hit_fan;
        if (cycle_done_i)
        begin
            // status shows only the cycle just finished; the event
            // pulses therefore appear for one cycle only
            stat_ts_next = pend_ts_reg | ev_ts;
            stat_an_next = pend_an_reg | hit_an;
            stat_fan_next = pend_fan_reg | hit_fan;
            pend_ts_next = STATUS_RESET;
            pend_an_next = STATUS_RESET;
            pend_fan_next = STATUS_RESET;
        end
    end

    // register read decode; reads have no side effect
    always_comb
    begin
        rd_valid_next = rd_en_i;
        rd_data_next = rd_data_reg;
        if (rd_en_i)
        begin
            unique case (rd_addr_i)
                ADDR_TEMP_SUPPLY: rd_data_next = stat_ts_reg;
                ADDR_ANALOG: rd_data_next = stat_an_reg;
                ADDR_FAN_TACH: rd_data_next = stat_fan_reg;
                default: rd_data_next = READ_UNMAPPED;
            endcase
        end
    end

    // alert request from any unmasked status bit
    always_comb
    begin
        alert_next = |(stat_ts_reg & ~mask_temp_supply_i)
            | |(stat_an_reg & ~mask_analog_i)
            | |(stat_fan_reg & ~mask_fan_i);
    end

    // state registers; the host has no write path to the status
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            thermal_alarm_mode_reg <= 2'h0;
            pend_ts_reg <= STATUS_RESET;
            pend_an_reg <= STATUS_RESET;
            pend_fan_reg <= STATUS_RESET;
            stat_ts_reg <= STATUS_RESET;
            stat_an_reg <= STATUS_RESET;
            stat_fan_reg <= STATUS_RESET;
            rd_data_reg <= READ_UNMAPPED;
            rd_valid_reg <= 1'b0;
            alert_reg <= 1'b0;
        end
        else
        begin
            thermal_alarm_mode_reg <= thermal_alarm_mode_next;
            pend_ts_reg <= pend_ts_next;
            pend_an_reg <= pend_an_next;
            pend_fan_reg <= pend_fan_next;
            stat_ts_reg <= stat_ts_next;
            stat_an_reg <= stat_an_next;
            stat_fan_reg <= stat_fan_next;
            rd_data_reg <= rd_data_next;
            rd_valid_reg <= rd_valid_next;
            alert_reg <= alert_next;
        end
    end

    // outputs straight from flops
    assign rd_data_o = rd_data_reg;
    assign rd_valid_o = rd_valid_reg;
    assign thermal_alarm_mode_active_o = thermal_alarm_mode_reg;
    assign alert_o = alert_reg;

    // status only moves when a conversion cycle closes
    status_hold_a: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        !cycle_done_i |=> $stable(stat_ts_reg) && $stable(stat_an_reg)
            && $stable(stat_fan_reg))
        else $error("status changed outside cycle end");

    // a read answers next cycle, misses read zero
    read_answer_a: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        rd_en_i && rd_addr_i != ADDR_TEMP_SUPPLY
            && rd_addr_i != ADDR_ANALOG && rd_addr_i != ADDR_FAN_TACH
        |=> rd_valid_o && rd_data_o == READ_UNMAPPED)
        else $error("unmapped read not answered with zero");

    // diode one miss in the closing cycle shows in bit0
    diode_one_a: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        cycle_done_i && meas_valid_i && meas_chan_i == CH_DIODE_ONE
            && (cmp.above || cmp.below)
        |=> stat_ts_reg[BIT_DIODE_ONE])
        else $error("diode one miss not flagged");

    // engage sets the mode and pulses the bit
    thermal_alarm_mode_engage_a: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        meas_valid_i && meas_chan_i == CH_DIODE_ONE && !thermal_alarm_mode_reg[0]
            && $signed(meas_value_i) > $signed(thermal_alarm_mode_lim_one_i)
        |=> thermal_alarm_mode_active_o[0]
            && (pend_ts_reg[BIT_DIODE_ONE] || stat_ts_reg[BIT_DIODE_ONE]))
        else $error("alarm engage not taken");
    // release needs the full hysteresis below the limit
    thermal_alarm_mode_release_a: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        meas_valid_i && meas_chan_i == CH_DIODE_ONE && thermal_alarm_mode_reg[0]
            && $signed(meas_value_i) >= $signed(thermal_alarm_mode_lim_one_i) - HYST_DEG_C
        |=> thermal_alarm_mode_active_o[0])
        else $error("alarm released inside hysteresis");
    // voltage mode routes aux nine into bit1
    aux_nine_a: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        cycle_done_i && diode_two_volt_mode_i && meas_valid_i
            && meas_chan_i == CH_AUX_NINE && (cmp.above || cmp.below)
        |=> stat_ts_reg[BIT_DIODE_TWO] && !thermal_alarm_mode_active_o[1])
        else $error("aux nine miss not in bit1");
    // analog channel zero lands in bit0 of the second byte
    analog_bit_a: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        cycle_done_i && meas_valid_i && meas_chan_i == CH_ANALOG_BASE
            && meas_value_i > meas_high_i
        |=> stat_an_reg[0])
        else $error("analog miss not flagged");
    // tach below its low limit never flags
    tach_high_a: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        cycle_done_i && meas_valid_i && meas_chan_i == CH_TACH_BASE
            && meas_value_i <= meas_high_i && !pend_fan_reg[0]
        |=> !stat_fan_reg[0])
        else $error("tach flagged on low limit");
    // fully masked status never raises the alert
    alert_mask_a: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        mask_temp_supply_i == 8'hFF && mask_analog_i == 8'hFF
            && mask_fan_i == 8'hFF |=> !alert_o)
        else $error("masked status raised alert");

endmodule : limit_status_registers
`default_nettype wire

// ==== verif/host_read_model.sv ====
// host side model issuing single-byte status register reads
`timescale 1ns/1ns
`default_nettype none
module host_read_model
(
    // clock
    input wire logic sys_clk_i,
    // read port towards the status bank
    output logic rd_en_o,
    output logic [7:0] rd_addr_o,
    input wire logic rd_valid_i,
    input wire logic [7:0] rd_data_i
);
    // idle port at time zero so no stray read is taken in reset
    initial
    begin
        rd_en_o = 1'b0;
        rd_addr_o = 8'h00;
    end

    // one byte read; ok only when the answer lands one cycle later
    task automatic read_reg(input logic [7:0] addr,
                            output logic [7:0] data, output bit ok);
        int n;
        ok = 1'b0;
        data = 8'h00;
        @(posedge sys_clk_i);
        rd_en_o <= 1'b1;
        rd_addr_o <= addr;
        @(posedge sys_clk_i);
        rd_en_o <= 1'b0;
        // bounded wait, a dead port must not hang the run
        for (n = 0; n < 4; n++)
        begin
            @(negedge sys_clk_i);
            if (rd_valid_i === 1'b1)
            begin
                data = rd_data_i;
                ok = (n == 0);
                break;
            end
        end
    endtask : read_reg
endmodule : host_read_model
`default_nettype wire

// ==== verif/tb_limit_status_registers.sv ====
// self-checking bench for the limit status register bank
`timescale 1ns/1ns
`default_nettype none
module tb_limit_status_registers
    import limit_status_pkg::*;
;
    // stimulus and observed signals
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic meas_valid = 1'b0;
    logic [4:0] meas_chan = 5'h00;
    logic [7:0] meas_value = 8'h00;
    logic [7:0] meas_high = 8'h00;
    logic [7:0] meas_low = 8'h00;
    logic cycle_done = 1'b0;
    logic [7:0] lim_one = 8'h7F; // high so the window sweep never alarms
    logic [7:0] lim_two = 8'h7F;
    logic volt_mode = 1'b0;
    logic [7:0] mask_ts = 8'h00;
    logic [7:0] mask_an = 8'h00;
    logic [7:0] mask_fan = 8'h00;
    logic rd_en;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;
    logic rd_valid;
    logic [1:0] thermal_alarm_mode_active;
    logic alert;
    // alarm walk: engage, hold, inside hysteresis, release, quiet
    logic [7:0] tv [5] = '{8'h41, 8'h41, 8'h3C, 8'h3A, 8'h3A};
    logic [4:0] ev = 5'b01001; // expected event pulse per step
    logic [4:0] av = 5'b00111; // expected alarm level per step
    int fails = 0;
    int num_checks = 0;

    // 250 MHz clock
    always #2 sys_clk = ~sys_clk;

    limit_status_registers DUT (
        .sys_clk_i(sys_clk),
        .rst_i(rst),
        .meas_valid_i(meas_valid),
        .meas_chan_i(meas_chan),
        .meas_value_i(meas_value),
        .meas_high_i(meas_high),
        .meas_low_i(meas_low),
        .cycle_done_i(cycle_done),
        .thermal_alarm_mode_lim_one_i(lim_one),
        .thermal_alarm_mode_lim_two_i(lim_two),
        .diode_two_volt_mode_i(volt_mode),
        .mask_temp_supply_i(mask_ts),
        .mask_analog_i(mask_an),
        .mask_fan_i(mask_fan),
        .rd_en_i(rd_en),
        .rd_addr_i(rd_addr),
        .rd_data_o(rd_data),
        .rd_valid_o(rd_valid),
        .thermal_alarm_mode_active_o(thermal_alarm_mode_active),
        .alert_o(alert)
    );

    host_read_model host (
        .sys_clk_i(sys_clk),
        .rd_en_o(rd_en),
        .rd_addr_o(rd_addr),
        .rd_valid_i(rd_valid),
        .rd_data_i(rd_data)
    );

    // verdict and end of run
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : wrap_up

    // one counted comparison, case equality so unknowns fail
    task automatic expect_eq(input logic [7:0] got, input logic [7:0] e,
                             input string what);
        num_checks++;
        if (got !== e)
        begin
            fails++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, e);
        end
    endtask : expect_eq

    // read a byte through the host and compare it
    task automatic chk_reg(input logic [7:0] addr, input logic [7:0] e);
        logic [7:0] d;
        bit ok;
        host.read_reg(addr, d, ok);
        if (!ok)
        begin
            fails++;
            $display("MISMATCH t=%0t late read answer at %h", $time, addr);
            wrap_up();
        end
        else
            expect_eq(d, e, "status byte");
    endtask : chk_reg

    // one result that also closes the conversion cycle
    task automatic conv(input logic [4:0] ch, input logic [7:0] v,
                        input logic [7:0] hi, input logic [7:0] lo);
        @(posedge sys_clk);
        meas_valid <= 1'b1;
        meas_chan <= ch;
        meas_value <= v;
        meas_high <= hi;
        meas_low <= lo;
        cycle_done <= 1'b1;
        @(posedge sys_clk);
        meas_valid <= 1'b0;
        cycle_done <= 1'b0;
        @(posedge sys_clk);
    endtask : conv

    // main sequence
    initial
    begin
        int c;
        int b;
        logic [7:0] a;
        logic [7:0] e;
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        // power-on values, then an unmapped byte
        chk_reg(ADDR_TEMP_SUPPLY, STATUS_RESET);
        chk_reg(ADDR_ANALOG, STATUS_RESET);
        chk_reg(ADDR_FAN_TACH, STATUS_RESET);
        chk_reg(8'h23, READ_UNMAPPED);
        $display("test reset_values done");
        // every channel but aux nine alone: odd above high, even below low
        for (c = 0; c < 25; c++)
        begin
            if (c == 2)
                continue;
            a = (c < CH_ANALOG_BASE) ? ADDR_TEMP_SUPPLY :
                (c < CH_TACH_BASE) ? ADDR_ANALOG : ADDR_FAN_TACH;
            b = (c < 2) ? c : (c < 9) ? c - 1 : (c < 17) ? c - 9 : c - 17;
            // tach has no low check, so its below case stays clear
            e = (c[0] || c < 17) ? 8'(1 << b) : 8'h00;
            conv(5'(c), c[0] ? 8'h50 : 8'h05, 8'h40, 8'h10);
            chk_reg(a, e);
        end
        // negative diode code must not read as a large value
        conv(CH_DIODE_ONE, 8'hF0, 8'h40, 8'h80);
        chk_reg(ADDR_TEMP_SUPPLY, 8'h00);
        conv(5'h1F, 8'h50, 8'h40, 8'h10);
        for (c = 0; c < 3; c++)
            chk_reg(ADDR_TEMP_SUPPLY + 8'(c), 8'h00);
        // first tach channel below its low limit stays clear
        conv(CH_TACH_BASE, 8'h05, 8'h40, 8'h10);
        chk_reg(ADDR_FAN_TACH, 8'h00);
        $display("test window_sweep done");
        // voltage mode moves bit one from diode two to aux nine
        @(posedge sys_clk);
        volt_mode <= 1'b1;
        conv(CH_AUX_NINE, 8'h50, 8'h40, 8'h10);
        chk_reg(ADDR_TEMP_SUPPLY, 8'h02);
        conv(CH_DIODE_TWO, 8'h50, 8'h40, 8'h10);
        chk_reg(ADDR_TEMP_SUPPLY, 8'h00);
        @(posedge sys_clk);
        volt_mode <= 1'b0;
        conv(CH_AUX_NINE, 8'h50, 8'h40, 8'h10);
        chk_reg(ADDR_TEMP_SUPPLY, 8'h00);
        $display("test voltage_mode done");
        // alarm mode events on each diode, window never missed
        @(posedge sys_clk);
        lim_one <= 8'h40;
        lim_two <= 8'h40;
        for (c = 0; c < 2; c++)
            for (b = 0; b < 5; b++)
            begin
                conv(5'(c), tv[b], 8'h7F, 8'h80);
                e = ev[b] ? 8'(1 << c) : 8'h00;
                chk_reg(ADDR_TEMP_SUPPLY, e);
                expect_eq(8'(thermal_alarm_mode_active[c]), 8'(av[b]), "alarm");
            end
        $display("test alarm_events done");
        // a masked bit keeps alert low, unmasking raises it
        @(posedge sys_clk);
        mask_ts <= 8'hFF;
        mask_an <= 8'h01;
        mask_fan <= 8'hFF;
        conv(CH_ANALOG_BASE, 8'h50, 8'h40, 8'h10);
        chk_reg(ADDR_ANALOG, 8'h01);
        expect_eq(8'(alert), 8'h00, "masked alert");
        // every mask set while a status bit stands
        @(posedge sys_clk);
        mask_an <= 8'hFF;
        @(negedge sys_clk);
        @(negedge sys_clk);
        expect_eq(8'(alert), 8'h00, "fully masked alert");
        @(posedge sys_clk);
        mask_an <= 8'h00;
        @(negedge sys_clk);
        @(negedge sys_clk);
        expect_eq(8'(alert), 8'h01, "unmasked alert");
        conv(CH_ANALOG_BASE, 8'h20, 8'h40, 8'h10);
        chk_reg(ADDR_ANALOG, 8'h00);
        expect_eq(8'(alert), 8'h00, "alert after clean cycle");
        $display("test mask_alert done");
        // misses gather over a cycle and stand until the next close
        @(posedge sys_clk);
        meas_valid <= 1'b1;
        meas_chan <= CH_RAIL_BASE;
        meas_value <= 8'h50;
        @(posedge sys_clk);
        meas_valid <= 1'b0;
        chk_reg(ADDR_TEMP_SUPPLY, 8'h00);
        conv(CH_DIODE_ONE, 8'h05, 8'h40, 8'h10);
        chk_reg(ADDR_TEMP_SUPPLY, 8'h05);
        chk_reg(ADDR_TEMP_SUPPLY, 8'h05);
        $display("test gather_cycle done");
        wrap_up();
    end
endmodule : tb_limit_status_registers
`default_nettype wire
